// ### common/adc_port_pkg.sv
// constants and types shared by the serial conversion port
//
// Overview of operation
// RQ1 - sample data input on rising serial clock edges
// RQ2 - select high: serial clock ignored on input
// RQ3 - data output changes on falling serial edges
// RQ4 - data output high impedance while select high
// RQ5 - internal mode: strobe low during conversion
// RQ6 - external mode: strobe high two periods before msb
// RQ7 - external mode: strobe tri-stated while select high
// RQ8 - external mode: serial clock paces the conversion
// RQ9 - shutdown pin low powers the device down
// RQ10 - first one after select falls starts byte
// RQ11 - external conversion ends at eighteenth falling edge
// RQ12 - mux at fifth falling edge, hold at eighth
// RQ13 - fourteen bit result shifted msb first
// RQ14 - remaining bits descend, one per falling edge
package adc_port_pkg;

	// ----------------------------------------
	// frame geometry, counted in serial clocks
	// ----------------------------------------
	localparam int CTRL_BITS = 8;        // control byte length
	localparam int RESULT_BITS = 14;     // conversion result width
	localparam int CNT_W = 5;            // width of the edge counter
	localparam logic [4:0] FRAME_EDGES = 5'h12;  // conversion complete edge (18)
	localparam logic [4:0] MUX_EDGE = 5'h05;     // mux switches to channel
	localparam logic [4:0] HOLD_EDGE = 5'h08;    // track/hold moves to hold
	localparam logic [4:0] STRB_EDGE = 5'h08;    // strobe rises here
	localparam logic [4:0] MSB_EDGE = 5'h0a;     // msb leaves on this edge

	// ----------------------------------------
	// control byte fields
	// ----------------------------------------
	localparam int CTL_START_POS = 7;    // start bit
	localparam int CTL_CHAN_POS = 4;     // low bit of channel select
	localparam int CTL_SGL_POS = 3;      // single ended / differential
	localparam int CTL_UNI_POS = 2;      // unipolar / bipolar
	localparam int CTL_PD_POS = 0;       // low bit of clock/power field
	localparam logic [1:0] PD_FULL_DOWN = 2'h0;  // full power-down
	localparam logic [1:0] PD_FAST_DOWN = 2'h1;  // fast power-down
	localparam logic [1:0] PD_INT_CLK = 2'h2;    // internal clock mode
	localparam logic [1:0] PD_EXT_CLK = 2'h3;    // external clock mode

	// ----------------------------------------
	// reset values and internal timing
	// ----------------------------------------
	localparam logic [7:0] CTL_RESET = 8'h00;    // control byte after reset
	localparam logic RESET_EXT_MODE = 1'b1;      // external clock until told
	localparam int INT_CONV_CYCLES = 15;         // oscillator cycles per conversion
	localparam int FIFO_DEPTH = 16;              // result buffer depth

	// decoded control byte
	typedef struct packed {
		logic start;          // always one in a taken byte
		logic [2:0] chan;     // channel select
		logic single_ended;   // 1 single ended, 0 differential
		logic unipolar;       // 1 unipolar, 0 bipolar
		logic [1:0] pd;       // clock and power-down mode
	} ctl_byte_s;

	// internal clock conversion states
	typedef enum logic [0:0] {
		CONV_IDLE = 1'b0,
		CONV_RUN = 1'b1
	} conv_state_e;

endpackage : adc_port_pkg

// ### src/adc_bit_sync.sv
// two flip-flop synchroniser for single-bit levels
`timescale 1ns/1ps
`default_nettype none
module adc_bit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	// first stage, read only by the second
	logic [WIDTH-1:0] meta;

	// ----------------------------------------
	// two stage capture
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : adc_bit_sync
`default_nettype wire

// ### src/adc_result_fifo.sv
// single clock result buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module adc_result_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	// storage, no reset needed
	logic [WIDTH-1:0] mem [DEPTH];
	// pointers carry one wrap bit
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic push;
	logic pop;

	// honest full and empty from the wrap bit
	assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
	assign out_valid = (wr_ptr != rd_ptr);
	assign out_data = mem[rd_ptr[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// ----------------------------------------
	// write side
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	// pointer updates
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule : adc_result_fifo
`default_nettype wire

// ### src/adc_serial_port.sv
// serial port and conversion sequencing of the multichannel converter
`timescale 1ns/1ps
`default_nettype none
module adc_serial_port #(
	parameter int RES_W = adc_port_pkg::RESULT_BITS,
	parameter int DEPTH = adc_port_pkg::FIFO_DEPTH,
	parameter int CONV_CYCLES = adc_port_pkg::INT_CONV_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic power_off_n,
	output logic dout_out,
	output logic dout_oe,
	output logic conversion_strobe_out,
	output logic conversion_strobe_oe,
	input wire logic [RES_W-1:0] sample_data,
	input wire logic sample_valid,
	output logic sample_ready,
	output adc_port_pkg::ctl_byte_s ctl_word,
	output logic ctl_update,
	output logic [2:0] mux_channel,
	output logic track_hold,
	output logic power_down
);
	localparam int STROBE_MAX = 40;  // bound on internal conversion, in clk_sys

	// ----------------------------------------
	// link side state (serial clock domain)
	// ----------------------------------------
	logic link_rst;                  // frame over, reset frame logic
	logic active;                    // start bit seen
	logic [adc_port_pkg::CNT_W-1:0] cnt;  // rising edges since start bit
	logic [7:0] shreg;               // incoming control bits
	logic [RES_W-1:0] result_word;   // word to shift out this frame
	logic ext_mode;                  // clock mode kept across frames
	logic ctl_tgl;                   // flips once per taken byte
	logic [7:0] ctl_held;            // stable byte for the other domain
	logic ack_tgl;                   // result handshake acknowledge
	logic req_s;                     // synchronised result request
	logic [RES_W-1:0] out_sr;        // result bits still to leave
	logic [4:0] out_left;            // count of bits still to leave
	logic strobe_ext;                // external mode strobe level

	// ----------------------------------------
	// system side state
	// ----------------------------------------
	logic [RES_W-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_pop;
	logic [RES_W-1:0] hold_word;     // word offered to the link
	logic req_tgl;                   // result handshake request
	logic pending;                   // word offered, not yet taken
	logic ack_s;                     // synchronised acknowledge
	logic ctl_s;                     // synchronised byte toggle
	logic ctl_prev;                  // previous synchronised toggle
	logic pwr_s;                     // synchronised shutdown pin
	logic ctl_evt;                   // new byte arrived
	logic strobe_int;                // internal mode strobe level
	logic pwr_low_s;                 // synchronised shutdown request
	logic byte_down;                 // last byte asked for power-down
	adc_port_pkg::conv_state_e conv_state;
	logic [7:0] conv_cnt;            // internal conversion cycles

	// reset, select high or shutdown clears the frame logic
	assign link_rst = rst | cs_n | ~power_off_n;  // [RQ2] [RQ9]

	// ----------------------------------------
	// result buffer, filled by the sar core
	// ----------------------------------------
	adc_result_fifo #(
		.WIDTH(RES_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(clk_sys),
		.rst(rst),
		.in_data(sample_data),
		.in_valid(sample_valid),
		.in_ready(sample_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	// crossings: request into the link, the rest into the system side
	adc_bit_sync #(.WIDTH(1)) u_req_sync (
		.clk(sclk),
		.rst(rst),
		.d(req_tgl),
		.q(req_s)
	);
	adc_bit_sync #(.WIDTH(3)) u_sys_sync (
		.clk(clk_sys),
		.rst(rst),
		.d({ack_tgl, ctl_tgl, ~power_off_n}),
		.q({ack_s, ctl_s, pwr_low_s})
	);
	// the sync idles at zero, so it carries the request, not the pin level
	assign pwr_s = ~pwr_low_s;

	// ----------------------------------------
	// rising edge: start detect and control byte
	// ----------------------------------------
	// input taken only while select is low; link_rst covers the rest
	always_ff @(posedge sclk or posedge link_rst) begin
		if (link_rst) begin
			active <= 1'b0;
			cnt <= '0;
			shreg <= adc_port_pkg::CTL_RESET;
		end else if (!active || cnt == adc_port_pkg::FRAME_EDGES) begin
			// leading zeros are skipped until the first one
			if (din) begin  // [RQ10] [RQ1]
				active <= 1'b1;
				cnt <= 5'h01;
				shreg <= {7'h00, din};
			end
		end else begin
			// serial clock paces the conversion up to its end
			cnt <= cnt + 5'h01;  // [RQ8] [RQ11]
			if (cnt < 5'(adc_port_pkg::CTRL_BITS)) begin
				shreg <= {shreg[6:0], din};  // [RQ1]
			end
		end
	end

	// byte complete: latch it, take the result, note the clock mode
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			ext_mode <= adc_port_pkg::RESET_EXT_MODE;
			ctl_tgl <= 1'b0;
			ctl_held <= adc_port_pkg::CTL_RESET;
			ack_tgl <= 1'b0;
			result_word <= '0;
		end else if (!cs_n && active
				&& cnt == 5'(adc_port_pkg::CTRL_BITS - 1)) begin
			ctl_held <= {shreg[6:0], din};
			ctl_tgl <= ~ctl_tgl;
			ext_mode <= ({shreg[0], din} == adc_port_pkg::PD_EXT_CLK);
			// a missing word reads as zero rather than a stale one
			if (req_s != ack_tgl) begin
				result_word <= hold_word;
				ack_tgl <= ~ack_tgl;
			end else begin
				result_word <= '0;
			end
		end
	end

	// ----------------------------------------
	// falling edge: output data and strobe
	// ----------------------------------------
	always_ff @(negedge sclk or posedge link_rst) begin
		if (link_rst) begin
			dout_out <= 1'b0;
			out_sr <= '0;
			out_left <= '0;
			strobe_ext <= 1'b0;
		end else begin
			// two periods high ending as the msb leaves
			if (active && cnt == adc_port_pkg::STRB_EDGE) begin
				strobe_ext <= 1'b1;  // [RQ6]
			end else if (active && cnt == adc_port_pkg::MSB_EDGE) begin
				strobe_ext <= 1'b0;  // [RQ6]
			end
			if (active && cnt == adc_port_pkg::MSB_EDGE) begin
				dout_out <= result_word[RES_W-1];  // [RQ13] [RQ3]
				out_sr <= {result_word[RES_W-2:0], 1'b0};
				out_left <= 5'(RES_W - 1);
			end else if (out_left != 5'h00) begin
				// descending order, one bit per edge
				dout_out <= out_sr[RES_W-1];  // [RQ14] [RQ3]
				out_sr <= {out_sr[RES_W-2:0], 1'b0};
				out_left <= out_left - 5'h01;
			end else begin
				dout_out <= 1'b0;
			end
		end
	end

	// analog controls survive select going high
	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			mux_channel <= 3'h0;
			track_hold <= 1'b0;
		end else if (!cs_n && active) begin
			if (cnt == adc_port_pkg::MUX_EDGE) begin
				mux_channel <= shreg[3:1];  // [RQ12]
			end
			if (cnt == adc_port_pkg::HOLD_EDGE) begin
				track_hold <= 1'b1;  // [RQ12]
			end else if (cnt == adc_port_pkg::FRAME_EDGES) begin
				track_hold <= 1'b0;  // [RQ11]
			end
		end
	end

	// pin enables follow select directly; strobe always driven in internal mode
	assign dout_oe = ~cs_n;  // [RQ4]
	assign conversion_strobe_oe = ext_mode ? ~cs_n : 1'b1;  // [RQ7]
	assign conversion_strobe_out = ext_mode ? strobe_ext : strobe_int;

	// ----------------------------------------
	// system side: result offer handshake
	// ----------------------------------------
	assign fifo_pop = !pending && fifo_valid;

	// one word offered at a time, held stable until acknowledged
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hold_word <= '0;
			req_tgl <= 1'b0;
			pending <= 1'b0;
		end else if (fifo_pop) begin
			hold_word <= fifo_data;
			req_tgl <= ~req_tgl;
			pending <= 1'b1;
		end else if (pending && ack_s == req_tgl) begin
			pending <= 1'b0;
		end
	end

	// ----------------------------------------
	// system side: control byte and shutdown
	// ----------------------------------------
	assign ctl_evt = ctl_s != ctl_prev;

	// byte is stable long before the toggle lands here
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctl_prev <= 1'b0;
			ctl_word <= adc_port_pkg::CTL_RESET;
			ctl_update <= 1'b0;
		end else begin
			ctl_prev <= ctl_s;
			ctl_update <= ctl_evt;
			if (ctl_evt) begin
				ctl_word <= ctl_held;
			end
		end
	end

	// true for the two byte codes that power the converter down
	function automatic logic pd_is_down(input logic [1:0] pd);
		return (pd == adc_port_pkg::PD_FULL_DOWN) || (pd == adc_port_pkg::PD_FAST_DOWN);
	endfunction : pd_is_down

	// byte mode kept apart, so lifting the pin restores it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			byte_down <= 1'b0;
		end else if (ctl_evt) begin
			byte_down <= pd_is_down(ctl_held[1:0]);
		end
	end

	// pin low or a power-down byte stops the converter
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			power_down <= 1'b0;
		end else if (!pwr_s) begin
			power_down <= 1'b1;  // [RQ9]
		end else if (ctl_evt) begin
			power_down <= pd_is_down(ctl_held[1:0]);
		end else begin
			// pin high again: back to what the last byte asked for
			power_down <= byte_down;  // [RQ9]
		end
	end

	// ----------------------------------------
	// internal clock conversion timing
	// ----------------------------------------
	// strobe low from conversion start until the oscillator count runs out
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			conv_state <= adc_port_pkg::CONV_IDLE;
			conv_cnt <= 8'h00;
			strobe_int <= 1'b1;
		end else begin
			unique case (conv_state)
				adc_port_pkg::CONV_IDLE: begin
					if (ctl_evt && pwr_s && ctl_held[1:0] == adc_port_pkg::PD_INT_CLK) begin
						conv_state <= adc_port_pkg::CONV_RUN;
						conv_cnt <= 8'(CONV_CYCLES - 1);
						strobe_int <= 1'b0;  // [RQ5]
					end
				end
				adc_port_pkg::CONV_RUN: begin
					// shutdown abandons the conversion
					if (conv_cnt == 8'h00 || !pwr_s) begin
						conv_state <= adc_port_pkg::CONV_IDLE;
						strobe_int <= 1'b1;  // [RQ5]
					end else begin
						conv_cnt <= conv_cnt - 8'h01;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence strobe_pair_s;
		strobe_ext ##1 strobe_ext ##1 !strobe_ext;
	endsequence

	// helper: falling edges seen in hold, checked when hold ends
	logic [4:0] hold_len;
	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			hold_len <= 5'h00;
		end else if (track_hold) begin
			hold_len <= hold_len + 5'h01;
		end else begin
			hold_len <= 5'h00;
		end
	end

	AST_START_DETECT: assert property (@(posedge sclk) disable iff (link_rst) // [RQ10]
		(!active && din) |=> (active && cnt == 5'h01))
		else $error("start bit not taken");
	AST_CNT_ADVANCE: assert property (@(posedge sclk) disable iff (link_rst) // [RQ8]
		(active && cnt != adc_port_pkg::FRAME_EDGES) |=> (cnt == $past(cnt) + 5'h01))
		else $error("edge counter did not advance");
	AST_STROBE_TWO: assert property (@(negedge sclk) disable iff (link_rst) // [RQ6]
		$rose(strobe_ext) |-> strobe_pair_s)
		else $error("strobe not two periods wide");
	AST_MSB_AFTER_STROBE: assert property (@(negedge sclk) disable iff (link_rst) // [RQ13]
		$fell(strobe_ext) |-> (dout_out == result_word[RES_W-1]))
		else $error("msb not on strobe fall");
	AST_SHIFT_DESC: assert property (@(negedge sclk) disable iff (link_rst) // [RQ14]
		(out_left != 5'h00 && cnt != adc_port_pkg::MSB_EDGE)
		|=> (dout_out == $past(out_sr[RES_W-1])))
		else $error("result bit out of order");
	AST_MUX_AT_FIVE: assert property (@(negedge sclk) disable iff (rst || cs_n) // [RQ12]
		(active && cnt == adc_port_pkg::MUX_EDGE) |=> (mux_channel == $past(shreg[3:1])))
		else $error("mux not switched on fifth edge");
	AST_HOLD_SPAN: assert property (@(negedge sclk) disable iff (rst || cs_n) // [RQ11]
		$fell(track_hold) |-> (hold_len == adc_port_pkg::FRAME_EDGES - adc_port_pkg::HOLD_EDGE))
		else $error("hold window wrong");
	AST_INT_STROBE: assert property (@(posedge clk_sys) disable iff (rst) // [RQ5]
		(conv_state == adc_port_pkg::CONV_IDLE && ctl_evt && pwr_s
			&& ctl_held[1:0] == adc_port_pkg::PD_INT_CLK)
		|=> !strobe_int ##[1:STROBE_MAX] strobe_int)
		else $error("internal strobe timing wrong");
	AST_SHUTDOWN: assert property (@(posedge clk_sys) disable iff (rst) // [RQ9]
		!pwr_s |=> (power_down && conv_state == adc_port_pkg::CONV_IDLE))
		else $error("shutdown not entered");
endmodule : adc_serial_port
`default_nettype wire

// ### bench/adc_host_model.sv
// host side of the serial link: sends control bytes and captures what comes back
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout_out,
	input wire logic dout_oe,
	input wire logic strobe_out,
	input wire logic strobe_oe,
	input wire logic [2:0] mux_channel,
	input wire logic track_hold
);
	localparam int HALF = 24; // half of the 48 ns link period
	logic [13:0] res; // result bits shifted in at rises 11..24
	int strobe_hi; // rises that saw the strobe high
	logic [2:0] mux_seen; // channel after the fifth fall
	logic hold_seen; // hold from fall 8 and track again after fall 18
	logic oe_seen; // both pin enables high all frame long

	// link clock stands still and select is high outside frames
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end

	// ------------------------------------------------
	// one conversion frame
	// ------------------------------------------------
	// ones clocked with select high must change nothing
	task automatic frame(input logic [7:0] ctl, input int lead);
		int k;
		int r;
		res = 14'h0000;
		strobe_hi = 0;
		oe_seen = 1'b1;
		for (k = 0; k < 3; k++) begin
			din = 1'b1;
			#HALF sclk = 1'b1;
			#HALF sclk = 1'b0;
		end
		din = 1'b0;
		#HALF cs_n = 1'b0; // held low for every bit
		// 24 clocks: 18 for the conversion, the rest to read the low bits
		for (k = 1; k <= lead + 24; k++) begin
			r = k - lead;
			din = (r >= 1 && r <= 8) ? ctl[8-r] : 1'b0; // zeros, then start bit first
			#HALF sclk = 1'b1;
			if (r >= 11) res = {res[12:0], dout_out};
			if (strobe_out === 1'b1) strobe_hi++;
			if (r == 6) mux_seen = mux_channel;
			if (r == 9) hold_seen = track_hold;
			if (r == 20) hold_seen = hold_seen & ~track_hold;
			oe_seen = oe_seen & dout_oe & strobe_oe;
			#HALF sclk = 1'b0;
		end
		#HALF cs_n = 1'b1;
		din = ~din; // no stale level left on the released line
	endtask : frame
endmodule : adc_host_model
`default_nettype wire

// ### bench/adc_serial_conversion_port_bench.sv
// self-checking bench of the serial conversion port against a queue model
`timescale 1ns/1ps
`default_nettype none
module adc_serial_conversion_port_bench;
	logic clk_sys, rst, power_off_n, sample_valid, took;
	logic [13:0] sample_data;
	wire sclk, cs_n, din;
	logic dout_out, dout_oe, strb_out, strb_oe, sample_ready, ctl_update, track_hold, power_down;
	logic [2:0] mux_channel;
	adc_port_pkg::ctl_byte_s ctl_word, last_ctl; // last byte announced by the update pulse
	logic [1:0] last_pd; // mode in force before the current frame
	logic [31:0] lfsr; // random source
	logic [13:0] model_q[$]; // words the buffer accepted, oldest first
	int bad_count, checked, cycles, n, m, low;

	adc_serial_port #(.CONV_CYCLES(adc_port_pkg::INT_CONV_CYCLES)) i_dut (
		.clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
		.power_off_n(power_off_n), .dout_out(dout_out), .dout_oe(dout_oe),
		.conversion_strobe_out(strb_out), .conversion_strobe_oe(strb_oe),
		.sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
		.ctl_word(ctl_word), .ctl_update(ctl_update), .mux_channel(mux_channel),
		.track_hold(track_hold), .power_down(power_down)
	);

	adc_host_model i_host (
		.sclk(sclk), .cs_n(cs_n), .din(din), .dout_out(dout_out), .dout_oe(dout_oe),
		.strobe_out(strb_out), .strobe_oe(strb_oe), .mux_channel(mux_channel),
		.track_hold(track_hold)
	);

	// ------------------------------------------------
	// clock, timeout and helpers
	// ------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// a hang costs a mismatch; the run needs about 1500 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			give_verdict();
		end
	end

	// keep the byte that the pulse announces, it is gone long before the frame ends
	always @(posedge clk_sys) begin
		if (ctl_update === 1'b1) last_ctl <= ctl_word;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	// offer one random word; ready is read off the edge, where the pointers are settled
	task automatic push(output logic ok);
		@(negedge clk_sys);
		lfsr = lfsr_next(lfsr);
		sample_data = lfsr[13:0];
		sample_valid = 1'b1;
		ok = sample_ready;
		if (ok === 1'b1) model_q.push_back(lfsr[13:0]);
		@(negedge clk_sys);
		sample_valid = 1'b0;
	endtask : push

	// one frame and its comparisons; an empty buffer yields zero
	task automatic convert(input logic [2:0] ch, input logic [1:0] pd, input int lead);
		logic [7:0] ctl;
		logic [13:0] exp;
		ctl = {1'b1, ch, 1'b1, 1'b1, pd};
		exp = (model_q.size() > 0) ? model_q.pop_front() : 14'h0000;
		i_host.frame(ctl, lead);
		repeat (4) @(posedge clk_sys); // host stalls between frames
		if (pd == adc_port_pkg::PD_EXT_CLK) begin
			check("result", 16'(i_host.res), 16'(exp));
		end
		if (pd == adc_port_pkg::PD_EXT_CLK && last_pd == adc_port_pkg::PD_EXT_CLK) begin
			check("strobe periods", 16'(i_host.strobe_hi), 16'h0002);
		end
		check("control byte", 16'(last_ctl), 16'(ctl));
		check("mux channel", 16'(i_host.mux_seen), 16'(ch));
		check("hold window", 16'(i_host.hold_seen), 16'h0001);
		check("enables in frame", 16'(i_host.oe_seen), 16'h0001);
		check("dout released", 16'(dout_oe), 16'h0000);
		last_pd = pd;
	endtask : convert

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		lfsr = 32'h139ad57e;
		rst = 1'b1;
		power_off_n = 1'b1;
		sample_valid = 1'b0;
		sample_data = 14'h0000;
		last_pd = adc_port_pkg::PD_EXT_CLK;
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		check("dout enable idle", 16'(dout_oe), 16'h0000);
		check("strobe enable idle", 16'(strb_oe), 16'h0000);
		// nothing buffered yet, leading zeros before the start bit
		convert(3'h2, adc_port_pkg::PD_EXT_CLK, 2);
		// fill until the buffer refuses
		took = 1'b1;
		n = 0;
		while (took === 1'b1 && n < 24) begin
			push(took);
			n++;
		end
		check("buffer refuses", 16'(took), 16'h0000);
		// drain: every conversion returns the oldest word
		while (model_q.size() > 0) begin
			lfsr = lfsr_next(lfsr);
			convert(lfsr[2:0], adc_port_pkg::PD_EXT_CLK, int'(lfsr[4:3]));
		end
		// every clock and power mode; internal mode times its own strobe
		for (m = 0; m < 4; m++) begin
			if (m == 2) begin
				fork
					convert(3'h5, 2'(m), 1);
					begin
						wait (ctl_update === 1'b1);
						low = 0;
						repeat (40) begin
							@(negedge clk_sys);
							if (strb_out === 1'b0) low++;
						end
					end
				join
				check("internal strobe low", 16'(low), 16'(adc_port_pkg::INT_CONV_CYCLES));
			end else begin
				convert(3'h1, 2'(m), 1);
			end
			check("mode power down", 16'(power_down), 16'(m < 2));
		end
		// shutdown pin, then a normal conversion again
		@(negedge clk_sys);
		power_off_n = 1'b0;
		repeat (8) @(posedge clk_sys);
		check("shutdown entered", 16'(power_down), 16'h0001);
		@(negedge clk_sys);
		power_off_n = 1'b1;
		repeat (8) @(posedge clk_sys);
		check("shutdown left", 16'(power_down), 16'h0000);
		convert(3'h7, adc_port_pkg::PD_EXT_CLK, 0);
		give_verdict();
	end
endmodule : adc_serial_conversion_port_bench
`default_nettype wire
